//--- design/extended_multicast_filter.sv
`timescale 1ns/100ps
// Operation
// RULE1: lookup table and its filtering exist only when the build option equals one.
// RULE2: a destination address is multicast when its bit 0 is one.
// RULE3: multicast frames are first checked for leading prefix 01:00:5E.
// RULE4: lookup index is the upper 15 bits of the 23-bit group part.
// RULE5: a set table entry accepts the frame and passes it upward.
// RULE6: drop when entry is zero or the prefix differs.
// RULE7: table is 32K one-bit entries, one 32-bit word address each.
// RULE8: software initialises every table entry before relying on filtering.
// RULE9: software runs the MAC promiscuous while extended filtering is used.
// RULE10: unicast low and high word registers filter unicast in promiscuous mode.
// RULE11: true promiscuous needs MAC promiscuous and enable bit 19 cleared.
// RULE12: entry bit 0 is read/write, resets zero (the table here has no reset); bits 31..1 read zero.
// RULE13: promiscuous control is the MSB of the filter select index register.
// RULE14: non-multicast frames skip the table; unicast and broadcast decide them.
module extended_multicast_filter
    import group_filter_pkg::*;
#(
    parameter bit GROUP_TABLE_BUILD_OPTION = 1'b1
) (
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic [ADDR_W-1:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [ADDR_W-1:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [DATA_W-1:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    input wire logic i_dest_valid,
    input wire logic [MAC_W-1:0] i_dest_addr,
    output logic o_verdict_valid,
    output logic o_verdict_accept
);
    typedef struct packed {
        logic wr_ready;
        logic rd_ready;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [DATA_W-1:0] rdata;
        logic extended_group_filter_enable;
        logic promiscuous;
        logic [FILTER_SELECT_INDEX_W-1:0] filter_select_index;
        logic [DATA_W-1:0] unicast_match_low_word;
        logic [UHI_W-1:0] unicast_match_high_word;
        logic verdict_valid;
        logic verdict_accept;
    } state_t;

    state_t s_q, s_d;
    logic wr_fire, rd_fire, wr_table, rd_table_sel;
    logic lookup_bit, bus_bit, filter_on, is_group, prefix_ok, is_bcast, ucast_hit;
    logic [INDEX_W-1:0] lookup_index, wr_index, rd_index;

    assign wr_fire = s_q.wr_ready && i_awvalid && i_wvalid;
    assign rd_fire = s_q.rd_ready && i_arvalid;
    assign rd_table_sel = i_araddr[TABLE_SEL_BIT];
    assign wr_table = wr_fire && i_awaddr[TABLE_SEL_BIT] && i_wstrb[0];
    assign wr_index = i_awaddr[TABLE_IDX_LSB +: INDEX_W];
    assign rd_index = i_araddr[TABLE_IDX_LSB +: INDEX_W];
    // RULE2: multicast test on first-octet LSB
    assign is_group = i_dest_addr[0];
    // RULE3: first received octet sits in the low byte
    assign prefix_ok = i_dest_addr[23:0] == GROUP_PREFIX;
    // RULE4: group bits 22..8 are octet four bits 6..0 then octet five
    assign lookup_index = {i_dest_addr[30:24], i_dest_addr[39:32]};
    assign is_bcast = i_dest_addr == BROADCAST_ADDR;
    assign ucast_hit = i_dest_addr == {s_q.unicast_match_high_word, s_q.unicast_match_low_word};
    // RULE1: filtering only in builds with the table
    assign filter_on = GROUP_TABLE_BUILD_OPTION && s_q.extended_group_filter_enable && s_q.promiscuous;

    // RULE1: table exists only in the extended build
    generate
        if (GROUP_TABLE_BUILD_OPTION) begin : g_table
            // RULE7: 32K deep, one bit per word address
            logic accept_table [TABLE_DEPTH];
            always_ff @(posedge i_clock) begin
                // RULE12: accept bit writable through bit 0
                if (wr_table) begin
                    accept_table[wr_index] <= i_wdata[ACCEPT_BIT];
                end
            end
            assign lookup_bit = accept_table[lookup_index];
            assign bus_bit = accept_table[rd_index];
        end else begin : g_no_table
            assign lookup_bit = 1'b0;
            assign bus_bit = 1'b0;
        end
    endgenerate

    always_comb begin
        s_d = s_q;
        // ready pulses once per request; valid must hold per the bus protocol
        s_d.wr_ready = i_awvalid && i_wvalid && !s_q.bvalid && !s_q.wr_ready;
        s_d.rd_ready = i_arvalid && !s_q.rvalid && !s_q.rd_ready;
        if (s_q.bvalid && i_bready) begin
            s_d.bvalid = 1'b0;
        end
        if (s_q.rvalid && i_rready) begin
            s_d.rvalid = 1'b0;
        end
        if (wr_fire) begin
            s_d.bvalid = 1'b1;
            s_d.bresp = RESP_OKAY;
            if (i_awaddr[TABLE_SEL_BIT]) begin
                if (!GROUP_TABLE_BUILD_OPTION) begin
                    s_d.bresp = RESP_SLVERR;
                end
            end else if (i_awaddr == FILTER_CONTROL_OFFSET) begin
                if (i_wstrb[2]) begin
                    s_d.extended_group_filter_enable = i_wdata[EXT_ENABLE_BIT];
                end
            end else if (i_awaddr == UNICAST_LOW_OFFSET) begin
                for (int b = 0; b < 4; b++) begin
                    if (i_wstrb[b]) begin
                        s_d.unicast_match_low_word[8*b +: 8] = i_wdata[8*b +: 8];
                    end
                end
            end else if (i_awaddr == UNICAST_HIGH_OFFSET) begin
                for (int b = 0; b < 2; b++) begin
                    if (i_wstrb[b]) begin
                        s_d.unicast_match_high_word[8*b +: 8] = i_wdata[8*b +: 8];
                    end
                end
            end else if (i_awaddr == FMI_OFFSET) begin
                // RULE13: promiscuous control in the index register MSB
                if (i_wstrb[3]) begin
                    s_d.promiscuous = i_wdata[PROM_BIT];
                end
                if (i_wstrb[0]) begin
                    s_d.filter_select_index = i_wdata[FILTER_SELECT_INDEX_W-1:0];
                end
            end else begin
                s_d.bresp = RESP_SLVERR;
            end
        end
        if (rd_fire) begin
            s_d.rvalid = 1'b1;
            s_d.rresp = RESP_OKAY;
            s_d.rdata = '0;
            if (rd_table_sel) begin
                // RULE12: upper bits of an entry read zero
                s_d.rdata[ACCEPT_BIT] = bus_bit;
                if (!GROUP_TABLE_BUILD_OPTION) begin
                    s_d.rresp = RESP_SLVERR;
                end
            end else if (i_araddr == FILTER_CONTROL_OFFSET) begin
                s_d.rdata[EXT_ENABLE_BIT] = s_q.extended_group_filter_enable;
            end else if (i_araddr == UNICAST_LOW_OFFSET) begin
                s_d.rdata = s_q.unicast_match_low_word;
            end else if (i_araddr == UNICAST_HIGH_OFFSET) begin
                s_d.rdata[UHI_W-1:0] = s_q.unicast_match_high_word;
            end else if (i_araddr == FMI_OFFSET) begin
                s_d.rdata[PROM_BIT] = s_q.promiscuous;
                s_d.rdata[FILTER_SELECT_INDEX_W-1:0] = s_q.filter_select_index;
            end else begin
                s_d.rresp = RESP_SLVERR;
            end
        end
        s_d.verdict_valid = i_dest_valid;
        if (i_dest_valid) begin
            if (!filter_on) begin
                // without the extended filter everything passes through
                s_d.verdict_accept = 1'b1;
            end else if (is_bcast) begin
                // RULE14: broadcast handled before the table
                s_d.verdict_accept = 1'b1;
            end else if (is_group) begin
                // RULE5: set entry with good prefix accepts; RULE6: else drop
                s_d.verdict_accept = prefix_ok && lookup_bit;
            end else begin
                // RULE10: unicast judged by the match registers
                s_d.verdict_accept = ucast_hit;
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            s_q <= '{wr_ready: 1'b0, rd_ready: 1'b0, bvalid: 1'b0, bresp: RESP_OKAY, rvalid: 1'b0,
                     rresp: RESP_OKAY, rdata: '0, extended_group_filter_enable: EXT_ENABLE_RST,
                     promiscuous: PROM_RST, filter_select_index: FILTER_SELECT_INDEX_RST,
                     unicast_match_low_word: UNICAST_LOW_RST, unicast_match_high_word: UNICAST_HIGH_RST,
                     verdict_valid: 1'b0, verdict_accept: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign o_awready = s_q.wr_ready;
    assign o_wready = s_q.wr_ready;
    assign o_bvalid = s_q.bvalid;
    assign o_bresp = s_q.bresp;
    assign o_arready = s_q.rd_ready;
    assign o_rvalid = s_q.rvalid;
    assign o_rresp = s_q.rresp;
    assign o_rdata = s_q.rdata;
    assign o_verdict_valid = s_q.verdict_valid;
    assign o_verdict_accept = s_q.verdict_accept;

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rstn);

    AST_DROP_PREFIX: assert property (i_dest_valid && filter_on && is_group && !is_bcast && !prefix_ok // RULE6
        |=> o_verdict_valid && !o_verdict_accept) else $error("bad prefix not dropped");
    AST_ACCEPT_ENTRY: assert property (i_dest_valid && filter_on && is_group && prefix_ok && lookup_bit // RULE5
        |=> o_verdict_valid && o_verdict_accept) else $error("set entry not accepted");
    AST_CLEAR_ENTRY: assert property (i_dest_valid && filter_on && is_group && prefix_ok && !lookup_bit // RULE6
        |=> !o_verdict_accept) else $error("clear entry accepted");
    AST_PASS_ALL: assert property (i_dest_valid && !filter_on |=> o_verdict_accept) // RULE1
        else $error("unfiltered frame dropped");
    AST_UNICAST: assert property (i_dest_valid && filter_on && !is_group && !ucast_hit // RULE10
        |=> !o_verdict_accept) else $error("unmatched unicast accepted");
    AST_ENTRY_UPPER: assert property (rd_fire && rd_table_sel |=> o_rvalid && o_rdata[31:1] == 31'h0) // RULE12
        else $error("entry upper bits not zero");
    AST_PROM_WRITE: assert property (wr_fire && i_awaddr == FMI_OFFSET && i_wstrb[3] // RULE13
        |=> o_bvalid && s_q.promiscuous == $past(i_wdata[PROM_BIT])) else $error("promiscuous bit not stored");
    AST_GROUP_BIT: assert property (i_dest_valid && filter_on && !i_dest_addr[0] && ucast_hit // RULE2
        |=> o_verdict_accept) else $error("unicast treated as multicast");
endmodule

//--- design/group_filter_pkg.sv
package group_filter_pkg;
    localparam int ADDR_W = 18;
    localparam int DATA_W = 32;
    localparam int MAC_W = 48;
    localparam int INDEX_W = 15;
    localparam int TABLE_DEPTH = 32768;
    // register byte offsets
    localparam logic [ADDR_W-1:0] FILTER_CONTROL_OFFSET = 18'h00000;
    localparam logic [ADDR_W-1:0] UNICAST_LOW_OFFSET = 18'h00020;
    localparam logic [ADDR_W-1:0] UNICAST_HIGH_OFFSET = 18'h00024;
    localparam logic [ADDR_W-1:0] FMI_OFFSET = 18'h00708;
    localparam logic [ADDR_W-1:0] TABLE_OFFSET = 18'h20000;
    // table window: address bit 17 set, word index in bits 16..2
    localparam int TABLE_SEL_BIT = 17;
    localparam int TABLE_IDX_LSB = 2;
    // field positions
    localparam int EXT_ENABLE_BIT = 19;
    localparam int PROM_BIT = 31;
    localparam int FILTER_SELECT_INDEX_W = 8;
    localparam int UHI_W = 16;
    localparam int ACCEPT_BIT = 0;
    // reset values
    localparam logic EXT_ENABLE_RST = 1'h0;
    localparam logic PROM_RST = 1'h0;
    localparam logic [FILTER_SELECT_INDEX_W-1:0] FILTER_SELECT_INDEX_RST = 8'h00;
    localparam logic [DATA_W-1:0] UNICAST_LOW_RST = 32'h00000000;
    localparam logic [UHI_W-1:0] UNICAST_HIGH_RST = 16'h0000;
    // address recognition
    localparam logic [23:0] GROUP_PREFIX = 24'h5E0001;
    localparam logic [MAC_W-1:0] BROADCAST_ADDR = 48'hFFFFFFFFFFFF;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- verification/frame_source.sv
`timescale 1ns/100ps
module frame_source
    import group_filter_pkg::*;
(
    input wire logic i_clock,
    output logic o_dest_valid,
    output logic [MAC_W-1:0] o_dest_addr,
    input wire logic i_verdict_valid,
    input wire logic i_verdict_accept
);
    initial begin
        o_dest_valid = 1'b0;
        o_dest_addr = '0;
    end
    task automatic send(input logic [MAC_W-1:0] a, output logic v, output logic acc);
        o_dest_valid <= 1'b1;
        o_dest_addr <= a;
        @(posedge i_clock);
        o_dest_valid <= 1'b0;
        // stale address inverted so a late sample cannot pass by luck
        o_dest_addr <= ~a;
        @(posedge i_clock);
        v = i_verdict_valid;
        acc = i_verdict_accept;
    endtask
endmodule

//--- verification/tb_top.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; $display("mismatch %s exp %h got %h", n, e, g); end end
module tb_top
    import group_filter_pkg::*;
;
    logic i_clock = 1'b0;
    logic i_rstn = 1'b0;
    logic [ADDR_W-1:0] awaddr = '0;
    logic [ADDR_W-1:0] araddr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, dv, vv, va;
    logic [1:0] bresp, rresp;
    logic [DATA_W-1:0] rdata;
    logic [MAC_W-1:0] da;
    int errors = 0;
    int cmp_count = 0;
    always #5 i_clock = ~i_clock;
    extended_multicast_filter uut (.i_clock(i_clock), .i_rstn(i_rstn), .i_awaddr(awaddr), .i_awvalid(awvalid),
        .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
        .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
        .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
        .i_dest_valid(dv), .i_dest_addr(da), .o_verdict_valid(vv), .o_verdict_accept(va));
    frame_source src (.i_clock(i_clock), .o_dest_valid(dv), .o_dest_addr(da), .i_verdict_valid(vv),
        .i_verdict_accept(va));
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic [1:0] er);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin @(posedge i_clock); n++; end while (awready !== 1'b1 && n < 20);
        `CHK("awready", 1'b1, awready)
        `CHK("wready", 1'b1, wready)
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        bready <= 1'b1;
        do begin @(posedge i_clock); n++; end while (bvalid !== 1'b1 && n < 40);
        `CHK("bvalid", 1'b1, bvalid)
        `CHK("bresp", er, bresp)
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        do begin @(posedge i_clock); n++; end while (arready !== 1'b1 && n < 20);
        `CHK("arready", 1'b1, arready)
        arvalid <= 1'b0;
        rready <= 1'b1;
        do begin @(posedge i_clock); n++; end while (rvalid !== 1'b1 && n < 40);
        `CHK("rvalid", 1'b1, rvalid)
        `CHK("rdata", ed, rdata)
        `CHK("rresp", er, rresp)
        rready <= 1'b0;
    endtask
    task automatic frame(input logic [MAC_W-1:0] a, input logic ea);
        logic v, acc;
        src.send(a, v, acc);
        `CHK("verdict_valid", 1'b1, v)
        `CHK("accept", ea, acc)
    endtask
    task automatic t_reset();
        rd(FILTER_CONTROL_OFFSET, 32'h00000000, RESP_OKAY);
        rd(FMI_OFFSET, 32'h00000000, RESP_OKAY);
        rd(UNICAST_LOW_OFFSET, 32'h00000000, RESP_OKAY);
        rd(UNICAST_HIGH_OFFSET, 32'h00000000, RESP_OKAY);
        frame(48'h5634125E0003, 1'b1);
        $display("test reset done");
    endtask
    task automatic t_table();
        wr(TABLE_OFFSET + 18'h048D0, 32'hFFFFFFFF, RESP_OKAY);
        wr(TABLE_OFFSET + 18'h048D4, 32'h00000000, RESP_OKAY);
        wr(TABLE_OFFSET + 18'h1FFFC, 32'h00000001, RESP_OKAY);
        rd(TABLE_OFFSET + 18'h048D0, 32'h00000001, RESP_OKAY);
        rd(TABLE_OFFSET + 18'h048D4, 32'h00000000, RESP_OKAY);
        rd(TABLE_OFFSET + 18'h1FFFC, 32'h00000001, RESP_OKAY);
        $display("test table done");
    endtask
    task automatic t_filter();
        wr(FILTER_CONTROL_OFFSET, 32'h00080000, RESP_OKAY);
        wr(FMI_OFFSET, 32'h800000A5, RESP_OKAY);
        rd(FMI_OFFSET, 32'h800000A5, RESP_OKAY);
        wr(UNICAST_LOW_OFFSET, 32'h44332200, RESP_OKAY);
        wr(UNICAST_HIGH_OFFSET, 32'h00006655, RESP_OKAY);
        frame(48'h5634125E0001, 1'b1);
        frame(48'h5635125E0001, 1'b0);
        frame(48'h5634125E0003, 1'b0);
        frame(48'hAA34925E0001, 1'b1);
        frame(48'h00FF7F5E0001, 1'b1);
        frame(48'hFFFFFFFFFFFF, 1'b1);
        frame(48'h665544332200, 1'b1);
        frame(48'h665544332202, 1'b0);
        wr(FILTER_CONTROL_OFFSET, 32'h00000000, RESP_OKAY);
        frame(48'h5635125E0001, 1'b1);
        $display("test filter done");
    endtask
    task automatic t_unmapped();
        wr(18'h00040, 32'h12345678, RESP_SLVERR);
        rd(18'h00040, 32'h00000000, RESP_SLVERR);
        $display("test unmapped done");
    endtask
    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge i_clock);
        i_rstn <= 1'b1;
        @(posedge i_clock);
        t_reset();
        t_table();
        t_filter();
        t_unmapped();
        close_out();
    end
    // tests need well under 1000 cycles
    initial begin
        #50000;
        errors++;
        close_out();
    end
endmodule
